// >>> hw/tcl_top.sv
// Two-train trip coincidence logic for the flux protection channels
module tcl_top
  import tcl_pkg::*;
(
  input  wire logic                  CLK_SYS,
  input  wire logic                  RSTN,
  input  wire logic                  CE,
  input  wire logic [TCL_PR_CH-1:0]  PR_HIGH_TRIP,
  input  wire logic [TCL_PR_CH-1:0]  PR_LOW_TRIP,
  input  wire logic [TCL_PR_CH-1:0]  PR_ABOVE_10,
  input  wire logic [TCL_PR_CH-1:0]  PR_RATE_POS,
  input  wire logic [TCL_PR_CH-1:0]  PR_RATE_NEG,
  input  wire logic [TCL_IR_CH-1:0]  IR_TRIP,
  input  wire logic [TCL_IR_CH-1:0]  IR_ABOVE_PERM,
  input  wire logic [TCL_IR_CH-1:0]  IR_TEST_BYPASS,
  input  wire logic [TCL_SR_CH-1:0]  SR_TRIP,
  input  wire logic [TCL_SR_CH-1:0]  SR_TEST_BYPASS,
  input  wire logic [TCL_TRAINS-1:0] PR_LOW_BYPASS_REQ,
  input  wire logic [TCL_TRAINS-1:0] IR_BLOCK_REQ,
  input  wire logic [TCL_TRAINS-1:0] SR_BYPASS_REQ,
  input  wire logic [TCL_TRAINS-1:0] SR_REINSTATE,
  input  wire logic [TCL_TRAINS-1:0] TRIP_RESET,
  output logic [TCL_TRAINS-1:0]      UV_HOLD,
  output logic [TCL_TRAINS-1:0]      SHUNT_HOLD,
  output logic [TCL_TRAINS-1:0]      TRIP_ACTIVE,
  output logic                       POWER_PERMISSIVE,
  output logic                       IR_PERMISSIVE,
  output logic                       IR_BYPASS_ANN,
  output logic                       SR_BYPASS_ANN,
  output logic [TCL_TRAINS-1:0]      PR_LOW_BYPASSED,
  output logic [TCL_TRAINS-1:0]      IR_BLOCKED,
  output logic [TCL_TRAINS-1:0]      SR_BYPASSED,
  output logic [TCL_TRAINS-1:0]      FLUX_RATE_TRIP,
  output logic [TCL_CAUSES-1:0]      TRIP_CAUSE_A,
  output logic [TCL_CAUSES-1:0]      TRIP_CAUSE_B
);
  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int unsigned NIN = 5 * TCL_PR_CH + 3 * TCL_IR_CH + 2 * TCL_SR_CH
                                + 5 * TCL_TRAINS;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] syn_in;

  assign raw_in = {PR_HIGH_TRIP, PR_LOW_TRIP, PR_ABOVE_10, PR_RATE_POS, PR_RATE_NEG,
                   IR_TRIP, IR_ABOVE_PERM, IR_TEST_BYPASS, SR_TRIP, SR_TEST_BYPASS,
                   PR_LOW_BYPASS_REQ, IR_BLOCK_REQ, SR_BYPASS_REQ, SR_REINSTATE,
                   TRIP_RESET};

  // Every pin passes four flops before any voting
  generate
    for (genvar i = 0; i < NIN; i++) begin : g_sync
      tcl_sync u_sync (
        .clk  (CLK_SYS),
        .rst_n(RSTN),
        .ce   (CE),
        .din  (raw_in[i]),
        .dout (syn_in[i])
      );
    end
  endgenerate

  logic [TCL_PR_CH-1:0]  pr_high;
  logic [TCL_PR_CH-1:0]  pr_low;
  logic [TCL_PR_CH-1:0]  pr_above;
  logic [TCL_PR_CH-1:0]  rate_pos;
  logic [TCL_PR_CH-1:0]  rate_neg;
  logic [TCL_IR_CH-1:0]  ir_trip;
  logic [TCL_IR_CH-1:0]  ir_above;
  logic [TCL_IR_CH-1:0]  ir_tbyp;
  logic [TCL_SR_CH-1:0]  sr_trip;
  logic [TCL_SR_CH-1:0]  sr_tbyp;
  logic [TCL_TRAINS-1:0] prl_req;
  logic [TCL_TRAINS-1:0] irb_req;
  logic [TCL_TRAINS-1:0] srb_req;
  logic [TCL_TRAINS-1:0] sr_rein;
  logic [TCL_TRAINS-1:0] rst_req;

  assign {pr_high, pr_low, pr_above, rate_pos, rate_neg, ir_trip, ir_above, ir_tbyp,
          sr_trip, sr_tbyp, prl_req, irb_req, srb_req, sr_rein, rst_req} = syn_in;

  ////////////////////////////////////////////////////////////////////////////
  // Coincidence voting

  function automatic logic [2:0] tcl_count4(input logic [TCL_PR_CH-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int k = 0; k < TCL_PR_CH; k++) begin
      n = n + {2'h0, v[k]};
    end
    return n;
  endfunction : tcl_count4

  logic       vote_prh;
  logic       vote_prl;
  logic       vote_rp;
  logic       vote_rn;
  logic       perm_set;
  logic       perm_clr;
  logic [2:0] n_below;

  assign n_below = tcl_count4(~pr_above);
  assign vote_prh = tcl_count4(pr_high) >= TCL_VOTE_TWO;
  assign vote_prl = tcl_count4(pr_low) >= TCL_VOTE_TWO;
  assign perm_set = tcl_count4(pr_above) >= TCL_VOTE_TWO;
  assign perm_clr = n_below >= TCL_VOTE_THREE;

  ////////////////////////////////////////////////////////////////////////////
  // State: permissive, per-train latches and bypass states

  typedef struct packed {
    logic                  perm;
    logic [TCL_PR_CH-1:0]  rp_lat;
    logic [TCL_PR_CH-1:0]  rn_lat;
    logic [TCL_TRAINS-1:0] prl_byp;
    logic [TCL_TRAINS-1:0] ir_blk;
    logic [TCL_TRAINS-1:0] sr_byp;
    logic [TCL_TRAINS-1:0] sr_rein_lat;
    tcl_state_e [TCL_TRAINS-1:0] st;
    logic [TCL_TRAINS-1:0] hold;
    logic [TCL_CAUSES-1:0] cause_a;
    logic [TCL_CAUSES-1:0] cause_b;
    logic                  ir_ann;
    logic                  sr_ann;
  } tcl_state_s;

  tcl_state_s s_q;
  tcl_state_s s_d;

  logic [TCL_CAUSES-1:0] cause_now [TCL_TRAINS];
  logic                  ir_perm;
  logic                  any_reset;

  // Intermediate permissive: one of two above; both below reinstates
  assign ir_perm = |ir_above;
  assign any_reset = |rst_req;

  always_comb begin
    s_d = s_q;
    for (int t = 0; t < TCL_TRAINS; t++) begin
      cause_now[t] = '0;
    end
    // Permissive keeps its value between the set and clear bands
    if (perm_set) begin
      s_d.perm = 1'b1;
    end else if (perm_clr) begin
      s_d.perm = 1'b0;
    end
    // Rate bistables latch until an operator reset with the input normal
    for (int c = 0; c < TCL_PR_CH; c++) begin
      if (rate_pos[c]) begin
        s_d.rp_lat[c] = 1'b1;
      end else if (any_reset) begin
        s_d.rp_lat[c] = 1'b0;
      end
      if (rate_neg[c]) begin
        s_d.rn_lat[c] = 1'b1;
      end else if (any_reset) begin
        s_d.rn_lat[c] = 1'b0;
      end
    end
    s_d.ir_ann = |ir_tbyp;
    s_d.sr_ann = |sr_tbyp;
    for (int t = 0; t < TCL_TRAINS; t++) begin
      // Manual bypasses need the permissive; losing it reinstates at once
      s_d.prl_byp[t] = s_q.perm & prl_req[t];
      s_d.ir_blk[t] = s_q.perm & irb_req[t];
      // Reinstate switch acts below the power permissive on its own train
      if (s_q.perm) begin
        s_d.sr_rein_lat[t] = 1'b0;
      end else if (sr_rein[t]) begin
        s_d.sr_rein_lat[t] = 1'b1;
      end
      // Power permissive bypasses outright; a reinstated train drops its manual bypass
      s_d.sr_byp[t] = s_q.perm
                      | (ir_perm & srb_req[t] & ~s_d.sr_rein_lat[t]);
      // Functions demanding a trip this cycle
      cause_now[t][TCL_C_PRH] = vote_prh;
      cause_now[t][TCL_C_PRL] = vote_prl & ~s_q.prl_byp[t];
      cause_now[t][TCL_C_IR] = |(ir_trip & ~ir_tbyp) & ~s_q.ir_blk[t];
      cause_now[t][TCL_C_SR] = |(sr_trip & ~sr_tbyp) & ~s_q.sr_byp[t];
      cause_now[t][TCL_C_RP] = tcl_count4(s_q.rp_lat) >= TCL_VOTE_TWO;
      cause_now[t][TCL_C_RN] = tcl_count4(s_q.rn_lat) >= TCL_VOTE_TWO;
      // Latched trip; reset refused while any initiator still tripped
      case (s_q.st[t])
        TCL_ARMED: begin
          if (|cause_now[t]) begin
            s_d.st[t] = TCL_TRIPPED;
          end
        end
        TCL_TRIPPED: begin
          if (rst_req[t] && !(|cause_now[t])) begin
            s_d.st[t] = TCL_ARMED;
          end
        end
        default: begin
          s_d.st[t] = TCL_TRIPPED;
        end
      endcase
      s_d.hold[t] = (s_d.st[t] == TCL_ARMED);
    end
    // Cause capture is sticky until the train rearms
    s_d.cause_a = (s_d.st[0] == TCL_ARMED) ? '0 : (s_q.cause_a | cause_now[0]);
    s_d.cause_b = (s_d.st[1] == TCL_ARMED) ? '0 : (s_q.cause_b | cause_now[1]);
  end

  // Reset leaves both trains tripped and both holds dropped
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      s_q <= '0;
      for (int t = 0; t < TCL_TRAINS; t++) begin
        s_q.st[t] <= TCL_TRIPPED;
      end
      s_q.hold <= {TCL_TRAINS{TCL_OUT_RST}};
      s_q.perm <= TCL_PERM_RST;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // One hold flop per train feeds both trip paths of that train only
  assign UV_HOLD = s_q.hold;
  assign SHUNT_HOLD = s_q.hold;
  assign TRIP_ACTIVE = ~s_q.hold;
  assign POWER_PERMISSIVE = s_q.perm;
  assign IR_PERMISSIVE = ir_perm;
  assign IR_BYPASS_ANN = s_q.ir_ann;
  assign SR_BYPASS_ANN = s_q.sr_ann;
  assign PR_LOW_BYPASSED = s_q.prl_byp;
  assign IR_BLOCKED = s_q.ir_blk;
  assign SR_BYPASSED = s_q.sr_byp;
  assign FLUX_RATE_TRIP = {s_q.cause_b[TCL_C_RP] | s_q.cause_b[TCL_C_RN],
                           s_q.cause_a[TCL_C_RP] | s_q.cause_a[TCL_C_RN]};
  assign TRIP_CAUSE_A = s_q.cause_a;
  assign TRIP_CAUSE_B = s_q.cause_b;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_prh_vote;
    vote_prh;
  endsequence

  sequence s_train_a_drop;
    ##1 !s_q.hold[0];
  endsequence

  prh_trips_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CE and s_prh_vote) |-> s_train_a_drop)
    else $error("high flux vote did not drop train A");

  shunt_tracks_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    SHUNT_HOLD == UV_HOLD)
    else $error("shunt output differs from undervoltage output");

  reset_refused_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CE && s_q.st[0] == TCL_TRIPPED && |cause_now[0]) |=> !UV_HOLD[0])
    else $error("train A rearmed with initiator tripped");

  perm_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CE && !perm_set && !perm_clr) |=> $stable(s_q.perm))
    else $error("permissive changed inside its band");

  perm_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CE && perm_clr && !perm_set) |=> !POWER_PERMISSIVE)
    else $error("permissive not cleared on three below");

  prl_bypass_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    PR_LOW_BYPASSED[0] |-> $past(s_q.perm))
    else $error("low setting bypassed without permissive");

  ir_block_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CE && !s_q.perm) |=> !IR_BLOCKED[1])
    else $error("intermediate block held without permissive");

  sr_auto_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CE && s_q.perm && !s_q.sr_rein_lat[0]) |=> SR_BYPASSED[0])
    else $error("source range not bypassed under permissive");

  rate_latch_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CE && s_q.rp_lat[0] && !any_reset) |=> s_q.rp_lat[0])
    else $error("rate latch released without reset");

  ir_trip_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (CE && ir_trip[0] && !ir_tbyp[0] && !s_q.ir_blk[1]) |=> TRIP_ACTIVE[1])
    else $error("intermediate trip missed on train B");
endmodule : tcl_top

// >>> hw/tcl_pkg.sv
// Package of constants and types for the trip coincidence logic
package tcl_pkg;
  // Channel counts
  localparam int unsigned TCL_PR_CH = 4;
  localparam int unsigned TCL_IR_CH = 2;
  localparam int unsigned TCL_SR_CH = 2;
  localparam int unsigned TCL_TRAINS = 2;
  // Voting thresholds
  localparam logic [2:0] TCL_VOTE_TWO = 3'h2;
  localparam logic [2:0] TCL_VOTE_THREE = 3'h3;
  // Reset values
  localparam logic TCL_PERM_RST = 1'b0;
  localparam logic TCL_OUT_RST = 1'b0;
  localparam logic [2:0] TCL_SYNC_RST = 3'h0;
  // Trip cause bits
  localparam int unsigned TCL_CAUSES = 6;
  localparam int unsigned TCL_C_PRH = 0;
  localparam int unsigned TCL_C_PRL = 1;
  localparam int unsigned TCL_C_IR = 2;
  localparam int unsigned TCL_C_SR = 3;
  localparam int unsigned TCL_C_RP = 4;
  localparam int unsigned TCL_C_RN = 5;
  typedef enum logic {TCL_ARMED, TCL_TRIPPED} tcl_state_e;
endpackage : tcl_pkg

// >>> hw/tcl_sync.sv
// Three-stage input synchroniser with agreement filter
module tcl_sync
  import tcl_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic [2:0] sh;
    logic       out;
  } tcl_sync_s;

  tcl_sync_s r_q;
  tcl_sync_s r_d;

  // Stage one is read only by stage two; output moves when two and three agree
  always_comb begin
    r_d = r_q;
    r_d.sh = {r_q.sh[1:0], din};
    if (r_q.sh[1] == r_q.sh[2]) begin
      r_d.out = r_q.sh[2];
    end
  end

  // Registered state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '0;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  assign dout = r_q.out;
endmodule : tcl_sync

// >>> tb/tcl_breaker_model.sv
// Trip breaker pair model standing behind the two logic trains
module tcl_breaker_model
  import tcl_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic [TCL_TRAINS-1:0] uv_hold,
  input  wire logic [TCL_TRAINS-1:0] shunt_hold,
  output logic      [TCL_TRAINS-1:0] brk_open,
  output logic                       rods_powered
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Coil loss or shunt release opens a breaker; either path alone suffices
  always_ff @(posedge clk) begin
    brk_open <= ~(uv_hold & shunt_hold);
  end

  // Breakers sit in series, so one open train cuts rod drive power
  assign rods_powered = ~|brk_open;
endmodule : tcl_breaker_model

// >>> tb/tcl_top_tb_top.sv
// Self-checking bench for the two-train trip coincidence logic
module tcl_top_tb_top
  import tcl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       CLK_SYS, RSTN, CE;
  logic [3:0] PR_HIGH_TRIP, PR_LOW_TRIP, PR_ABOVE_10, PR_RATE_POS, PR_RATE_NEG;
  logic [1:0] IR_TRIP, IR_ABOVE_PERM, IR_TEST_BYPASS, SR_TRIP, SR_TEST_BYPASS;
  logic [1:0] PR_LOW_BYPASS_REQ, IR_BLOCK_REQ, SR_BYPASS_REQ, SR_REINSTATE, TRIP_RESET;
  logic [1:0] UV_HOLD, SHUNT_HOLD, TRIP_ACTIVE, PR_LOW_BYPASSED, IR_BLOCKED, SR_BYPASSED;
  logic [1:0] FLUX_RATE_TRIP, brk_open;
  logic       POWER_PERMISSIVE, IR_PERMISSIVE, IR_BYPASS_ANN, SR_BYPASS_ANN, rods_powered;
  logic [5:0] TRIP_CAUSE_A, TRIP_CAUSE_B;
  int         n_mismatch = 0;
  int         total_checks = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Design and far-side breaker model
  tcl_top tcl_top_i (
    .CLK_SYS, .RSTN, .CE, .PR_HIGH_TRIP, .PR_LOW_TRIP, .PR_ABOVE_10, .PR_RATE_POS,
    .PR_RATE_NEG, .IR_TRIP, .IR_ABOVE_PERM, .IR_TEST_BYPASS, .SR_TRIP, .SR_TEST_BYPASS,
    .PR_LOW_BYPASS_REQ, .IR_BLOCK_REQ, .SR_BYPASS_REQ, .SR_REINSTATE, .TRIP_RESET,
    .UV_HOLD, .SHUNT_HOLD, .TRIP_ACTIVE, .POWER_PERMISSIVE, .IR_PERMISSIVE,
    .IR_BYPASS_ANN, .SR_BYPASS_ANN, .PR_LOW_BYPASSED, .IR_BLOCKED, .SR_BYPASSED,
    .FLUX_RATE_TRIP, .TRIP_CAUSE_A, .TRIP_CAUSE_B
  );
  tcl_breaker_model tcl_breaker_model_i (
    .clk(CLK_SYS), .uv_hold(UV_HOLD), .shunt_hold(SHUNT_HOLD),
    .brk_open(brk_open), .rods_powered(rods_powered)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 8 ns period
  initial begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end

  // Shared helpers
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge CLK_SYS);
  endtask : wait_cyc

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Operator reset held long enough to pass the synchroniser
  task automatic rearm();
    TRIP_RESET = 2'h3;
    wait_cyc(12);
    TRIP_RESET = 2'h0;
    wait_cyc(2);
    chk(UV_HOLD, 8'h03, "rearm");
  endtask : rearm

  task automatic complete_run();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_state();
    chk(UV_HOLD, 8'h00, "uv in reset");
    chk(TRIP_ACTIVE, 8'h03, "active in reset");
    wait_cyc(12);
    chk(SHUNT_HOLD, 8'h00, "stays tripped");
    rearm();
    chk(rods_powered, 8'h01, "rods powered");
  endtask : t_reset_state

  task automatic t_pr_high();
    CE = 1'b0;
    PR_HIGH_TRIP = 4'h3;
    wait_cyc(10);
    chk(UV_HOLD, 8'h03, "frozen by enable");
    CE = 1'b1;
    PR_HIGH_TRIP = 4'h1;
    wait_cyc(12);
    chk(UV_HOLD, 8'h03, "one of four");
    PR_HIGH_TRIP = 4'h3;
    wait_cyc(8);
    chk(UV_HOLD, 8'h00, "two of four");
    chk(SHUNT_HOLD, 8'h00, "shunt drop");
    chk(TRIP_CAUSE_A, 8'h01, "cause");
    chk(brk_open, 8'h03, "breakers open");
    TRIP_RESET = 2'h3;
    wait_cyc(10);
    chk(UV_HOLD, 8'h00, "reset refused");
    PR_HIGH_TRIP = 4'h0;
    wait_cyc(12);
    chk(UV_HOLD, 8'h03, "reset taken");
    TRIP_RESET = 2'h0;
    wait_cyc(2);
  endtask : t_pr_high

  // One-of-two functions and their per-channel test bypass
  task automatic t_one_of_two(input int k);
    if (k == 0) IR_TEST_BYPASS = 2'h1;
    else SR_TEST_BYPASS = 2'h1;
    if (k == 0) IR_TRIP = 2'h1;
    else SR_TRIP = 2'h1;
    wait_cyc(10);
    chk(UV_HOLD, 8'h03, "bypassed channel");
    chk(k == 0 ? IR_BYPASS_ANN : SR_BYPASS_ANN, 8'h01, "bypass ann");
    IR_TRIP = (k == 0) ? 2'h2 : 2'h0;
    SR_TRIP = (k == 0) ? 2'h0 : 2'h2;
    wait_cyc(10);
    chk(UV_HOLD, 8'h00, "one of two");
    chk(TRIP_CAUSE_B[2+k], 8'h01, "cause");
    {IR_TRIP, SR_TRIP, IR_TEST_BYPASS, SR_TEST_BYPASS} = 8'h00;
    wait_cyc(8);
    rearm();
  endtask : t_one_of_two

  task automatic t_sr_manual();
    SR_BYPASS_REQ = 2'h1;
    wait_cyc(10);
    chk(SR_BYPASSED, 8'h00, "no ir permissive");
    IR_ABOVE_PERM = 2'h2;
    wait_cyc(10);
    chk({IR_PERMISSIVE, SR_BYPASSED}, 8'h05, "sr bypass");
    SR_TRIP = 2'h1;
    wait_cyc(10);
    chk(UV_HOLD, 8'h01, "train b only");
    SR_TRIP = 2'h0;
    IR_ABOVE_PERM = 2'h0;
    wait_cyc(10);
    chk(SR_BYPASSED, 8'h00, "reinstated");
    SR_BYPASS_REQ = 2'h0;
    rearm();
  endtask : t_sr_manual

  task automatic t_perm();
    PR_LOW_BYPASS_REQ = 2'h3;
    IR_BLOCK_REQ = 2'h3;
    wait_cyc(10);
    chk({PR_LOW_BYPASSED, IR_BLOCKED}, 8'h00, "no permissive");
    PR_ABOVE_10 = 4'h3;
    wait_cyc(10);
    chk(POWER_PERMISSIVE, 8'h01, "perm set");
    chk({PR_LOW_BYPASSED, IR_BLOCKED}, 8'h0f, "bypass on");
    chk(SR_BYPASSED, 8'h03, "sr auto");
    PR_LOW_TRIP = 4'hf;
    SR_TRIP = 2'h3;
    IR_TRIP = 2'h3;
    wait_cyc(10);
    chk(UV_HOLD, 8'h03, "all bypassed");
    {PR_LOW_TRIP, SR_TRIP, IR_TRIP} = 8'h00;
    PR_ABOVE_10 = 4'h1;
    wait_cyc(10);
    chk(POWER_PERMISSIVE, 8'h00, "perm clear");
    chk({PR_LOW_BYPASSED, IR_BLOCKED}, 8'h00, "bypass off");
    PR_LOW_TRIP = 4'h3;
    wait_cyc(10);
    chk(UV_HOLD, 8'h00, "low trip back");
    PR_LOW_TRIP = 4'h0;
    {PR_LOW_BYPASS_REQ, IR_BLOCK_REQ} = 4'h0;
    wait_cyc(8);
    rearm();
    SR_BYPASS_REQ = 2'h3;
    IR_ABOVE_PERM = 2'h1;
    wait_cyc(10);
    chk(SR_BYPASSED, 8'h03, "manual sr bypass");
    SR_REINSTATE = 2'h1;
    wait_cyc(8);
    SR_REINSTATE = 2'h0;
    wait_cyc(2);
    chk(SR_BYPASSED, 8'h02, "own train only");
    PR_ABOVE_10 = 4'hc;
    wait_cyc(10);
    chk(SR_BYPASSED, 8'h03, "auto over reinstate");
    {PR_ABOVE_10, SR_BYPASS_REQ, IR_ABOVE_PERM} = 8'h00;
    wait_cyc(10);
  endtask : t_perm

  // Short rate pulse must still run to a full trip
  task automatic t_rate(input int k);
    if (k == 0) PR_RATE_POS = 4'h6;
    else PR_RATE_NEG = 4'h9;
    wait_cyc(6);
    {PR_RATE_POS, PR_RATE_NEG} = 8'h00;
    wait_cyc(10);
    chk(UV_HOLD, 8'h00, "rate latched");
    chk(FLUX_RATE_TRIP, 8'h03, "rate trip");
    chk(TRIP_CAUSE_A[4+k], 8'h01, "rate cause");
    rearm();
  endtask : t_rate

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    RSTN = 1'b0;
    CE = 1'b1;
    {PR_HIGH_TRIP, PR_LOW_TRIP, PR_ABOVE_10, PR_RATE_POS, PR_RATE_NEG} = 20'h0;
    {IR_TRIP, IR_ABOVE_PERM, IR_TEST_BYPASS, SR_TRIP, SR_TEST_BYPASS} = 10'h0;
    {PR_LOW_BYPASS_REQ, IR_BLOCK_REQ, SR_BYPASS_REQ, SR_REINSTATE, TRIP_RESET} = 10'h0;
    wait_cyc(8);
    chk({UV_HOLD, TRIP_ACTIVE}, 8'h03, "held in reset");
    RSTN = 1'b1;
    t_reset_state();
    t_pr_high();
    for (int k = 0; k < 2; k++) t_one_of_two(k);
    t_sr_manual();
    for (int k = 0; k < 2; k++) t_rate(k);
    t_perm();
    RSTN = 1'b0;
    wait_cyc(1);
    chk(UV_HOLD, 8'h00, "second reset");
    wait_cyc(7);
    RSTN = 1'b1;
    t_reset_state();
    complete_run();
  end

  // Watchdog well beyond the roughly 430 cycles of stimulus
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    n_mismatch++;
    complete_run();
  end
endmodule : tcl_top_tb_top
